//--- design/drc_defs.svh
// Register map, field positions, reset values and timing counts of the DMA request block
`ifndef DRC_DEFS_SVH
`define DRC_DEFS_SVH

// Register indices; byte address on APB is four times the index
`define DRC_IDX_CTRL 16'h1078
`define DRC_IDX_DROP 16'h107a
`define DRC_IDX_IRQ_STAT 16'h1080
`define DRC_IDX_IRQ_MASK 16'h1081
`define DRC_ADDR_W 18

// Control register fields
`define DRC_CNT_MSB 6
`define DRC_POL_BIT 12
`define DRC_EDGE_BIT 13
`define DRC_PAUSE_BIT 14
`define DRC_EN_BIT 15
`define DRC_DROP_MSB 9

// Reset values
`define DRC_CTRL_RST 16'h0000
`define DRC_DROP_RST 16'h0000
`define DRC_IRQ_RST 2'h0

// Interrupt status bits
`define DRC_IRQ_DONE 0
`define DRC_IRQ_PAUSE 1
`define DRC_IRQ_N 2

// Pulse-mode request width: typical time, clock rate, derived count (rounded up)
`define DRC_PULSE_NS 250
`define DRC_CLK_MHZ 20
`define DRC_PULSE_CYC ((`DRC_PULSE_NS * `DRC_CLK_MHZ + 999) / 1000)

`endif

//--- design/drc_pkg.sv
// Types shared by the DMA request block
package drc_pkg;

  // Request sequencer states, one-hot
  typedef enum logic [2:0] {
    DRC_IDLE = 3'b001,
    DRC_ASSERT = 3'b010,
    DRC_WAIT = 3'b100
  } drc_state_e;

  // Control register contents
  typedef struct packed {
    logic dma_en;
    logic pause;
    logic pulse_mode;
    logic request_polarity;
    logic [6:0] sector_count;
  } drc_ctrl_s;

  // Events from the data path
  typedef struct packed {
    logic sector_done;
    logic ecc_error;
    logic bus_cycle_start;
  } drc_evt_s;

endpackage : drc_pkg

//--- design/drc_pulse_timer.sv
// Down-counter that times the fixed-width request pulse
`timescale 1ns/1ps
module drc_pulse_timer #(
  parameter int CYCLES = 5,
  parameter int W = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic start,
  input wire logic cancel,
  output logic expire
);

  logic [W-1:0] cnt;

  // Load on start, count to zero; cancel wins so a paused pulse ends at once
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= '0;
    end else if (cancel) begin
      cnt <= '0;
    end else if (start) begin
      cnt <= W'(CYCLES - 1);
    end else if (cnt != '0) begin
      cnt <= cnt - W'(1);
    end
  end

  // Last cycle of the pulse; counting down to zero keeps the active time at CYCLES
  assign expire = !cancel && !start && (cnt == '0);

endmodule : drc_pulse_timer

//--- design/drc_irq_ctrl.sv
// Sticky interrupt status with write-one-to-clear, mask and one level output
`timescale 1ns/1ps
`include "drc_defs.svh"
module drc_irq_ctrl #(
  parameter int N = 2
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [N-1:0] events,
  input wire logic clear_wr,
  input wire logic mask_wr,
  input wire logic [N-1:0] wdata,
  output logic [N-1:0] status,
  output logic [N-1:0] mask,
  output logic irq
);

  // Sticky bits; a new event beats a clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status <= N'(`DRC_IRQ_RST);
    end else begin
      status <= events | (status & ~(clear_wr ? wdata : '0));
    end
  end

  // Mask register, one means enabled
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask <= N'(`DRC_IRQ_RST);
    end else if (mask_wr) begin
      mask <= wdata;
    end
  end

  // Output from a flop, follows status one cycle later
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(status & mask);
    end
  end

endmodule : drc_irq_ctrl

//--- design/drc_request_ctrl.sv
// DMA request control: sector counter, enable, pause and request output with APB registers
// Behaviour
// - Seven-bit sector counter in control bits 6-0 holds sectors minus one.
// - Writing zero to the counter means exactly one sector to transfer.
// - Counter reading zero means one sector still outstanding, not finished.
// - Counter decrements by one after each sector's checksum is read.
// - After an error the counter still shows sectors left.
// - Polarity zero: request idles high, goes low to ask.
// - Polarity one: request idles low, goes high to ask.
// - Pulse mode: each block starts with a request pulse of about 250 ns.
// - Level mode: request held, dropped when byte counter hits drop point.
// - Checksum error during DMA sets pause and stops the operation.
// - Setting enable bit 15 starts DMA operation.
// - Reserved bits read zero and ignore writes.
`timescale 1ns/1ps
`include "drc_defs.svh"
module drc_request_ctrl #(
  parameter int PULSE_CYCLES = `DRC_PULSE_CYC,
  parameter int DROP_W = 10
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic sector_done,
  input wire logic ecc_error,
  input wire logic bus_cycle_start,
  input wire logic [DROP_W-1:0] transfer_byte_counter,
  output logic transfer_request_out,
  output logic dma_active,
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  drc_pkg::drc_ctrl_s ctrl;
  logic [6:0] sector_count;
  logic request_polarity;
  logic pulse_mode;
  logic pause;
  logic dma_en;
  drc_pkg::drc_evt_s evt;
  drc_pkg::drc_state_e state;
  drc_pkg::drc_state_e next_state;
  logic [DROP_W-1:0] drop_point;
  logic [`DRC_IRQ_N-1:0] irq_status;
  logic [`DRC_IRQ_N-1:0] irq_mask;
  logic [`DRC_IRQ_N-1:0] irq_events;
  logic setup;
  logic access;
  logic wr_ctrl;
  logic wr_drop;
  logic wr_stat;
  logic wr_mask;
  logic hit_ctrl;
  logic hit_drop;
  logic hit_stat;
  logic hit_mask;
  logic pulse_expire;
  logic pulse_start;
  logic level_drop;
  logic last_sector;
  logic sector_end;
  logic req_active;
  logic [15:0] ctrl_word;

  assign evt = '{sector_done: sector_done, ecc_error: ecc_error,
                 bus_cycle_start: bus_cycle_start};

  // Fields kept in separate flops so each has a single writer
  assign ctrl = '{dma_en: dma_en, pause: pause, pulse_mode: pulse_mode,
                  request_polarity: request_polarity, sector_count: sector_count};

  ////////////////////////////////////////////////////////////////////////////
  // APB decode

  // Word address compare; unaligned or foreign addresses fall to the error answer
  always_comb begin
    hit_ctrl = 1'b0;
    hit_drop = 1'b0;
    hit_stat = 1'b0;
    hit_mask = 1'b0;
    if (paddr == 32'({`DRC_IDX_CTRL, 2'h0})) begin
      hit_ctrl = 1'b1;
    end else if (paddr == 32'({`DRC_IDX_DROP, 2'h0})) begin
      hit_drop = 1'b1;
    end else if (paddr == 32'({`DRC_IDX_IRQ_STAT, 2'h0})) begin
      hit_stat = 1'b1;
    end else if (paddr == 32'({`DRC_IDX_IRQ_MASK, 2'h0})) begin
      hit_mask = 1'b1;
    end
  end

  assign setup = psel && !penable;
  // Writes land only at the edge where pready is sampled high
  assign access = psel && penable && pready;
  assign wr_ctrl = access && pwrite && hit_ctrl;
  assign wr_drop = access && pwrite && hit_drop;
  assign wr_stat = access && pwrite && hit_stat;
  assign wr_mask = access && pwrite && hit_mask;

  // Reserved bits are simply not stored, so they read zero
  assign ctrl_word = {ctrl.dma_en, ctrl.pause, ctrl.pulse_mode, ctrl.request_polarity,
                      5'h00, ctrl.sector_count};

  // No wait state: answer is prepared in setup, taken at the first access edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= setup;
      pslverr <= setup && !(hit_ctrl || hit_drop || hit_stat || hit_mask);
    end
  end

  // Read data captured in setup; upper bits always zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (setup && !pwrite) begin
      if (hit_ctrl) begin
        prdata <= {16'h0000, ctrl_word};
      end else if (hit_drop) begin
        prdata <= 32'(drop_point);
      end else if (hit_stat) begin
        prdata <= 32'(irq_status);
      end else if (hit_mask) begin
        prdata <= 32'(irq_mask);
      end else begin
        prdata <= 32'h0000_0000;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control fields

  assign sector_end = evt.sector_done && (state == drc_pkg::DRC_WAIT);
  assign last_sector = sector_end && (ctrl.sector_count == 7'h00);

  // Sector counter: zero still means one sector; a software write beats the decrement
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sector_count <= 7'(`DRC_CTRL_RST);
    end else if (wr_ctrl) begin
      sector_count <= pwdata[`DRC_CNT_MSB:0];
    end else if (sector_end && !last_sector) begin
      sector_count <= sector_count - 7'h01;
    end
  end

  // Mode bits, plain software storage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      request_polarity <= 1'b0;
      pulse_mode <= 1'b0;
    end else if (wr_ctrl) begin
      request_polarity <= pwdata[`DRC_POL_BIT];
      pulse_mode <= pwdata[`DRC_EDGE_BIT];
    end
  end

  // Enable: set by software, cleared when the last sector completes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dma_en <= 1'b0;
    end else if (wr_ctrl) begin
      dma_en <= pwdata[`DRC_EN_BIT];
    end else if (last_sector) begin
      dma_en <= 1'b0;
    end
  end

  // Pause: a checksum error during DMA sets it and wins over a clearing write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pause <= 1'b0;
    end else if (evt.ecc_error && ctrl.dma_en) begin
      pause <= 1'b1;
    end else if (wr_ctrl) begin
      pause <= pwdata[`DRC_PAUSE_BIT];
    end
  end

  // Drop point, ten bits; upper bits not stored
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      drop_point <= DROP_W'(`DRC_DROP_RST);
    end else if (wr_drop) begin
      drop_point <= pwdata[DROP_W-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Request sequencer

  assign pulse_start = (state == drc_pkg::DRC_IDLE) && (next_state == drc_pkg::DRC_ASSERT);
  // Compare happens in the cycle the bus cycle starts; the state leaves assert one edge later, the output drops two edges later
  assign level_drop = evt.bus_cycle_start && (transfer_byte_counter == drop_point);

  // A new sector starts only from idle, enabled and not paused
  always_comb begin
    next_state = state;
    case (state)
      drc_pkg::DRC_IDLE: begin
        if (ctrl.dma_en && !ctrl.pause && !evt.ecc_error) begin
          next_state = drc_pkg::DRC_ASSERT;
        end
      end
      drc_pkg::DRC_ASSERT: begin
        if (evt.ecc_error || !ctrl.dma_en) begin
          next_state = drc_pkg::DRC_IDLE;
        end else if (ctrl.pulse_mode ? pulse_expire : level_drop) begin
          next_state = drc_pkg::DRC_WAIT;
        end
      end
      drc_pkg::DRC_WAIT: begin
        if (evt.ecc_error || !ctrl.dma_en || evt.sector_done) begin
          next_state = drc_pkg::DRC_IDLE;
        end
      end
      default: begin
        next_state = drc_pkg::DRC_IDLE;
      end
    endcase
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= drc_pkg::DRC_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Pulse width timer
  drc_pulse_timer #(
    .CYCLES(PULSE_CYCLES),
    .W(8)
  ) u_pulse_timer (
    .pclk(pclk),
    .presetn(presetn),
    .start(pulse_start),
    .cancel(evt.ecc_error),
    .expire(pulse_expire)
  );

  assign req_active = (state == drc_pkg::DRC_ASSERT) && !ctrl.pause;

  // Request pin from a flop; polarity picks the idle level
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      transfer_request_out <= 1'b1;
    end else if (ctrl.request_polarity) begin
      transfer_request_out <= req_active;
    end else begin
      transfer_request_out <= !req_active;
    end
  end

  // Busy indicator for the surrounding data path
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dma_active <= 1'b0;
    end else begin
      dma_active <= ctrl.dma_en && !ctrl.pause;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupts

  // Whole transfer finished, and transfer stopped by a checksum error
  assign irq_events = {evt.ecc_error && ctrl.dma_en, last_sector};

  drc_irq_ctrl #(
    .N(`DRC_IRQ_N)
  ) u_irq (
    .pclk(pclk),
    .presetn(presetn),
    .events(irq_events),
    .clear_wr(wr_stat),
    .mask_wr(wr_mask),
    .wdata(pwdata[`DRC_IRQ_N-1:0]),
    .status(irq_status),
    .mask(irq_mask),
    .irq(irq)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  property p_pause_on_error;
    @(posedge pclk) disable iff (!presetn)
    ecc_error && ctrl.dma_en |=> ctrl.pause && state == drc_pkg::DRC_IDLE;
  endproperty
  a_pause_on_error: assert property (p_pause_on_error)
    else $error("pause not set or request not stopped after error");

  property p_no_request_paused;
    @(posedge pclk) disable iff (!presetn)
    ctrl.pause ##1 ctrl.pause |-> transfer_request_out == !$past(ctrl.request_polarity);
  endproperty
  a_no_request_paused: assert property (p_no_request_paused)
    else $error("request active while paused");

  property p_polarity;
    @(posedge pclk) disable iff (!presetn)
    1'b1 |=> transfer_request_out == ($past(ctrl.request_polarity) ~^ $past(req_active));
  endproperty
  a_polarity: assert property (p_polarity)
    else $error("request level does not match polarity");

  property p_pulse_width;
    @(posedge pclk) disable iff (!presetn)
    pulse_start && ctrl.pulse_mode ##1 (!ecc_error && ctrl.dma_en && !wr_ctrl)[*5]
      |=> state != drc_pkg::DRC_ASSERT && $past(state, 1) == drc_pkg::DRC_ASSERT;
  endproperty
  a_pulse_width: assert property (p_pulse_width)
    else $error("request pulse not five cycles long");

  property p_level_drop;
    @(posedge pclk) disable iff (!presetn)
    state == drc_pkg::DRC_ASSERT && !ctrl.pulse_mode && level_drop
      |=> state != drc_pkg::DRC_ASSERT ##1 transfer_request_out == !ctrl.request_polarity;
  endproperty
  a_level_drop: assert property (p_level_drop)
    else $error("level request not dropped at drop point");

  property p_decrement;
    @(posedge pclk) disable iff (!presetn)
    sector_end && ctrl.sector_count != 7'h00 && !wr_ctrl
      |=> ctrl.sector_count == $past(ctrl.sector_count) - 7'h01;
  endproperty
  a_decrement: assert property (p_decrement)
    else $error("sector counter not decremented");

  property p_last_sector;
    @(posedge pclk) disable iff (!presetn)
    sector_end && ctrl.sector_count == 7'h00 && !wr_ctrl
      |=> !ctrl.dma_en && ctrl.sector_count == 7'h00;
  endproperty
  a_last_sector: assert property (p_last_sector)
    else $error("zero count did not finish after one more sector");

  property p_count_on_error;
    @(posedge pclk) disable iff (!presetn)
    ecc_error && !wr_ctrl && !sector_end |=> $stable(ctrl.sector_count);
  endproperty
  a_count_on_error: assert property (p_count_on_error)
    else $error("sector counter changed on error");

  property p_start;
    @(posedge pclk) disable iff (!presetn)
    state == drc_pkg::DRC_IDLE && ctrl.dma_en && !ctrl.pause && !ecc_error
      |=> state == drc_pkg::DRC_ASSERT ##1 transfer_request_out == ctrl.request_polarity;
  endproperty
  a_start: assert property (p_start)
    else $error("enabled idle sequencer did not request");

  property p_reserved_read;
    @(posedge pclk) disable iff (!presetn)
    access && !pwrite && hit_ctrl |-> prdata[11:7] == 5'h00 && prdata[31:16] == 16'h0000;
  endproperty
  a_reserved_read: assert property (p_reserved_read)
    else $error("reserved bits read nonzero");

  property p_count_written;
    @(posedge pclk) disable iff (!presetn)
    wr_ctrl |=> ctrl.sector_count == $past(pwdata[6:0]) && drop_point == $past(drop_point);
  endproperty
  a_count_written: assert property (p_count_written)
    else $error("written sector count not stored");

endmodule : drc_request_ctrl

//--- tb/drc_host_model.sv
// Host DMA controller model facing the request output of the DMA request block
`timescale 1ns/1ps
module drc_host_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic req,
  input wire logic pol,
  input wire logic level,
  input wire logic [9:0] drop,
  input wire logic inject_err,
  output logic bus_cycle_start,
  output logic [9:0] byte_count,
  output logic sector_done,
  output logic ecc_error,
  output logic [7:0] req_count,
  output logic [7:0] last_width,
  output logic [7:0] lag,
  output logic [7:0] n_bcs
);
  logic act_q;
  logic matched;
  logic [7:0] width;
  logic [1:0] gap;
  logic [9:0] left;
  wire logic act = (req == pol);

  ////////////////////////////////////////////////////////////////////////////////
  // Counts requests, times them, runs bus cycles and ends each sector
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      act_q <= 1'b0;
      matched <= 1'b0;
      width <= 8'h00;
      gap <= 2'h0;
      left <= 10'h000;
      bus_cycle_start <= 1'b0;
      byte_count <= 10'h155;
      sector_done <= 1'b0;
      ecc_error <= 1'b0;
      req_count <= 8'h00;
      last_width <= 8'h00;
      lag <= 8'h00;
      n_bcs <= 8'h00;
    end else begin
      act_q <= act;
      sector_done <= 1'b0;
      ecc_error <= 1'b0;
      bus_cycle_start <= 1'b0;
      // Released bus: toggles so a stale value never looks valid
      byte_count <= ~byte_count;
      if (act && !act_q) begin
        req_count <= req_count + 8'h01;
        width <= 8'h01;
        left <= drop + 10'h003;
        matched <= 1'b0;
        n_bcs <= 8'h00;
        lag <= 8'h00;
      end else if (act) begin
        width <= width + 8'h01;
      end
      // Level mode: count down towards the drop point, one bus cycle per clock
      if (act && act_q && level && !matched) begin
        bus_cycle_start <= 1'b1;
        byte_count <= left;
        n_bcs <= n_bcs + 8'h01;
        if (left == drop) matched <= 1'b1;
        else left <= left - 10'h001;
      end
      if (act && act_q && matched) lag <= lag + 8'h01;
      // Sector ends only after the request phase is over
      if (!act && act_q) begin
        last_width <= width;
        gap <= 2'h2;
      end else if (gap != 2'h0) begin
        gap <= gap - 2'h1;
        if (gap == 2'h1 && inject_err) ecc_error <= 1'b1;
        else if (gap == 2'h1) sector_done <= 1'b1;
      end
    end
  end
endmodule : drc_host_model

//--- tb/test_drc_request_ctrl.sv
// Self-checking testbench of the DMA request block over APB
`timescale 1ns/1ps
`include "drc_defs.svh"
module test_drc_request_ctrl;
  localparam int PW = 5;
  localparam logic [31:0] A_CTRL = 32'(`DRC_IDX_CTRL) << 2;
  localparam logic [31:0] A_DROP = 32'(`DRC_IDX_DROP) << 2;
  localparam logic [31:0] A_STAT = 32'(`DRC_IDX_IRQ_STAT) << 2;
  localparam logic [31:0] A_MASK = 32'(`DRC_IDX_IRQ_MASK) << 2;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] paddr = 32'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, sector_done, ecc_error, bus_cycle_start;
  logic req, dma_active, irq;
  logic [9:0] byte_count;
  logic pol = 1'b0;
  logic level = 1'b0;
  logic [9:0] drop = 10'h0;
  logic inject_err = 1'b0;
  logic [7:0] req_count, last_width, lag, n_bcs, base;
  int num_errors = 0;
  int num_checks = 0;

  // Clock
  always #25 pclk = ~pclk;

  drc_request_ctrl #(.PULSE_CYCLES(PW), .DROP_W(10)) drc_request_ctrl_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sector_done(sector_done), .ecc_error(ecc_error), .bus_cycle_start(bus_cycle_start),
    .transfer_byte_counter(byte_count), .transfer_request_out(req),
    .dma_active(dma_active), .irq(irq));

  drc_host_model drc_host_model_i (
    .pclk(pclk), .presetn(presetn), .req(req), .pol(pol), .level(level), .drop(drop),
    .inject_err(inject_err), .bus_cycle_start(bus_cycle_start), .byte_count(byte_count),
    .sector_done(sector_done), .ecc_error(ecc_error), .req_count(req_count),
    .last_width(last_width), .lag(lag), .n_bcs(n_bcs));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic conclude;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : conclude

  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t value %h expected %h", $time, got, exp);
    end
  endtask : chk_val

  task automatic chk_bit(input logic got, input logic exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t flag %b expected %b", $time, got, exp);
    end
  endtask : chk_bit

  // One APB transfer; answer is taken at the rising edge where pready is seen high
  task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic err);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Values read right after the edge are those the design sampled there
    for (n = 0; n < 20; n++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (n == 20) begin
      num_errors++;
      $display("[FAIL] %0t no ready", $time);
      conclude();
    end
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask : wr

  task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp, input logic exp_err);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, 32'h0, q, e);
    chk_val(q, exp);
    chk_bit(e, exp_err);
  endtask : rd_chk

  // Polls a register bit until it reaches the wanted value
  task automatic wait_bit(input logic [31:0] a, input int b, input logic v);
    logic [31:0] q;
    logic e;
    int n;
    for (n = 0; n < 200; n++) begin
      apb(1'b0, a, 32'h0, q, e);
      if (q[b] === v) break;
    end
    if (n == 200) begin
      num_errors++;
      $display("[FAIL] %0t wait timed out", $time);
      conclude();
    end
  endtask : wait_bit

  task automatic settle(input int n);
    repeat (n) @(posedge pclk);
    @(negedge pclk);
  endtask : settle

  ////////////////////////////////////////////////////////////////////////////////
  // Watchdog
  initial begin
    repeat (20000) @(posedge pclk);
    num_errors++;
    $display("[FAIL] %0t run timed out", $time);
    conclude();
  end

  // Main sequence
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rd_chk(A_CTRL, 32'h0, 1'b0);
    rd_chk(A_DROP, 32'h0, 1'b0);
    rd_chk(A_STAT, 32'h0, 1'b0);
    rd_chk(A_MASK, 32'h0, 1'b0);
    chk_bit(req, 1'b1);
    wr(A_CTRL, 32'h0f80);
    rd_chk(A_CTRL, 32'h0, 1'b0);
    wr(A_DROP, 32'hffff);
    rd_chk(A_DROP, 32'h3ff, 1'b0);
    rd_chk(32'h4300, 32'h0, 1'b1);
    $display("registers done");
    // Idle level follows the polarity bit
    wr(A_CTRL, 32'h1000);
    pol <= 1'b1;
    settle(4);
    chk_bit(req, 1'b0);
    $display("polarity done");
    // Pulse mode, three sectors back to back
    base = req_count;
    wr(A_CTRL, 32'hb002);
    wait_bit(A_CTRL, 15, 1'b0);
    chk_val(32'(8'(req_count - base)), 32'd3);
    chk_val(32'(last_width), 32'(PW));
    rd_chk(A_CTRL, 32'h3000, 1'b0);
    rd_chk(A_STAT, 32'h1, 1'b0);
    chk_bit(irq, 1'b0);
    wr(A_MASK, 32'h3);
    settle(2);
    chk_bit(irq, 1'b1);
    wr(A_STAT, 32'h1);
    settle(2);
    chk_bit(irq, 1'b0);
    $display("pulse done");
    // Level mode, one sector, 10-bit host drop point
    wr(A_CTRL, 32'h0);
    pol <= 1'b0;
    level <= 1'b1;
    settle(6);
    base = req_count;
    drop <= 10'd20;
    wr(A_DROP, 32'd20);
    wr(A_CTRL, 32'h8000);
    rd_chk(A_CTRL, 32'h8000, 1'b0);
    wait_bit(A_CTRL, 15, 1'b0);
    chk_val(32'(8'(req_count - base)), 32'd1);
    chk_val(32'(n_bcs), 32'd4);
    chk_val(32'(lag), 32'd2);
    wr(A_STAT, 32'h1);
    $display("level done");
    // Checksum error on the first of two sectors
    level <= 1'b0;
    inject_err <= 1'b1;
    base = req_count;
    wr(A_CTRL, 32'ha001);
    wait_bit(A_STAT, 1, 1'b1);
    inject_err <= 1'b0;
    rd_chk(A_CTRL, 32'he001, 1'b0);
    chk_bit(irq, 1'b1);
    settle(20);
    chk_bit(req, 1'b1);
    chk_bit(dma_active, 1'b0);
    chk_val(32'(8'(req_count - base)), 32'd1);
    wr(A_STAT, 32'h2);
    wr(A_CTRL, 32'ha001);
    wait_bit(A_CTRL, 15, 1'b0);
    chk_val(32'(8'(req_count - base)), 32'd3);
    rd_chk(A_CTRL, 32'h2000, 1'b0);
    $display("error done");
    conclude();
  end
endmodule : test_drc_request_ctrl
